// *** hw/mixer_route_pkg.sv ***
// Purpose: shared constants and types for the mixer input source router
// Assumes: one clock, 32-bit Avalon-MM register access
// Notes: sample words are AES3 subframes without preamble
`default_nettype none
package mixer_route_pkg;
    localparam int PAIR_COUNT = 8;
    localparam int SDI_CHANS = 16;
    localparam int AES_CHANS = 16;
    localparam int ANALOG_CHANS = 4;
    localparam int DECODE_CHANS = 8;
    localparam int ADDR_W = 6;

    // -----------------------------------------------------------------
    // register map, byte addresses
    // -----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CFG_BASE = 6'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 6'h20;

    // -----------------------------------------------------------------
    // config word fields and reset value
    // -----------------------------------------------------------------
    localparam int SRC_LSB = 0;
    localparam int PAIRSEL_LSB = 4;
    localparam int MODE_LSB = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam int STAT_DECODE_BIT = 0;
    localparam int STAT_NONAUDIO_LSB = 8;
    localparam int STAT_BYPASS_LSB = 16;

    localparam logic [1:0] SRC_SDI = 2'h0;
    localparam logic [1:0] SRC_AES = 2'h1;
    localparam logic [1:0] SRC_ANALOG = 2'h2;
    localparam logic [1:0] SRC_DECODE = 2'h3;
    localparam logic [1:0] MODE_AUDIO = 2'h0;
    localparam logic [1:0] MODE_DATA = 2'h1;
    localparam logic [1:0] MODE_AUTO = 2'h2;

    // pairs the analog and decoder sources can offer
    localparam logic [2:0] ANALOG_PAIR_LIMIT = 3'h2;
    localparam logic [2:0] DECODE_PAIR_LIMIT = 3'h4;

    // channel status bit that flags non-audio content, counted in frames
    localparam logic [7:0] CS_NONAUDIO_FRAME = 8'h01;
    localparam logic [7:0] CS_FRAME_LAST = 8'hbf;

    typedef struct packed {
        logic blockStart;
        logic parity;
        logic chanStat;
        logic user;
        logic validity;
        logic [23:0] audio;
    } aes_word_type;

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] pairSel;
        logic [1:0] source;
    } pair_cfg_type;

    typedef struct packed {
        aes_word_type left;
        aes_word_type right;
        logic ok;
    } pick_type;

    typedef struct packed {
        aes_word_type left;
        aes_word_type right;
        logic valid;
        logic bypass;
    } mix_pair_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avs_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avs_rsp_type;
endpackage
`default_nettype wire

// *** hw/pair_mode_unit.sv ***
// Purpose: per-pair mode handling and output register for one mixer pair
// Assumes: picked words are steady while sampleStrobe is high
// Notes: auto detection restarts whenever the pair's routing changes
`default_nettype none
module pair_mode_unit (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sampleStrobe,
    input wire mixer_route_pkg::pair_cfg_type cfg,
    input wire mixer_route_pkg::pick_type pick,
    output var mixer_route_pkg::mix_pair_type outPair,
    output var logic nonAudio
);
    import mixer_route_pkg::*;

    typedef struct packed {
        logic [7:0] frameIdx;
        logic nonAudio;
        logic [4:0] route;
        mix_pair_type out;
    } unit_state_type;

    unit_state_type state;
    unit_state_type next_state;
    logic [7:0] idx;

    always_comb begin
        next_state = state;
        idx = 8'h00;
        next_state.out.valid = 1'b0;
        next_state.route = {cfg.pairSel, cfg.source};
        if (state.route != next_state.route) begin
            // new stream: old detection means nothing for it
            next_state.nonAudio = 1'b0;
            next_state.frameIdx = CS_FRAME_LAST;
        end else if (sampleStrobe) begin
            if (pick.left.blockStart) begin
                idx = 8'h00;
            end else if (state.frameIdx != CS_FRAME_LAST) begin
                idx = state.frameIdx + 8'h01;
            end else begin
                idx = CS_FRAME_LAST;
            end
            next_state.frameIdx = idx;
            if (pick.ok && idx == CS_NONAUDIO_FRAME) begin
                next_state.nonAudio = pick.left.chanStat;
            end
            // words pass whole, all flag bits kept
            next_state.out.left = pick.ok ? pick.left : '0;
            next_state.out.right = pick.ok ? pick.right : '0;
            next_state.out.valid = pick.ok;
            case (cfg.mode)
                MODE_DATA: next_state.out.bypass = 1'b1;
                MODE_AUTO: next_state.out.bypass = next_state.nonAudio;
                default: next_state.out.bypass = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign outPair = state.out;
    assign nonAudio = state.nonAudio;

    a_word_intact: assert property (@(posedge clk_sys) disable iff (rst)
        (sampleStrobe && pick.ok && state.route == {cfg.pairSel, cfg.source})
        |=> outPair.left == $past(pick.left) && outPair.right == $past(pick.right))
        else $error("picked words were altered");
endmodule
`default_nettype wire

// *** hw/mixer_input_source_router.sv ***
// Purpose: choose, per mixer input pair, the source and channel pair that feed it
// Assumes: all source words and sampleStrobe come from logic on clk_sys
// Notes: registers over Avalon-MM; every access answers after one wait cycle
`default_nettype none
module mixer_input_source_router (
    input wire logic clk_sys,
    input wire logic rst,
    input wire mixer_route_pkg::avs_req_type avsReq,
    output var mixer_route_pkg::avs_rsp_type avsRsp,
    input wire logic decoderActive,
    input wire logic sampleStrobe,
    input wire mixer_route_pkg::aes_word_type [15:0] sdiWords,
    input wire mixer_route_pkg::aes_word_type [15:0] aesWords,
    input wire mixer_route_pkg::aes_word_type [3:0] analogWords,
    input wire mixer_route_pkg::aes_word_type [7:0] decodeWords,
    output var mixer_route_pkg::mix_pair_type [7:0] mixPairs
);
    import mixer_route_pkg::*;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic pair_cfg_type word_to_cfg(input logic [31:0] w);
        pair_cfg_type c;
        c.source = w[SRC_LSB +: 2];
        c.pairSel = w[PAIRSEL_LSB +: 3];
        c.mode = w[MODE_LSB +: 2];
        return c;
    endfunction

    function automatic logic [31:0] cfg_to_word(input pair_cfg_type c);
        logic [31:0] w;
        w = '0;
        w[SRC_LSB +: 2] = c.source;
        w[PAIRSEL_LSB +: 3] = c.pairSel;
        w[MODE_LSB +: 2] = c.mode;
        return w;
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return m;
    endfunction

    // both selectors together name one source pair
    function automatic pick_type select_source(
        input pair_cfg_type c,
        input logic decOn,
        input aes_word_type [15:0] sdi,
        input aes_word_type [15:0] aes,
        input aes_word_type [3:0] ana,
        input aes_word_type [7:0] dec
    );
        pick_type r;
        r = '0;
        case (c.source)
            SRC_SDI: begin
                // eight embedded pairs; this path also runs during embedding
                r.left = sdi[{c.pairSel, 1'b0}];
                r.right = sdi[{c.pairSel, 1'b1}];
                r.ok = 1'b1;
            end
            SRC_AES: begin
                r.left = aes[{c.pairSel, 1'b0}];
                r.right = aes[{c.pairSel, 1'b1}];
                r.ok = 1'b1;
            end
            SRC_ANALOG: begin
                if (c.pairSel < ANALOG_PAIR_LIMIT) begin
                    r.left = ana[{c.pairSel[0], 1'b0}];
                    r.right = ana[{c.pairSel[0], 1'b1}];
                    r.ok = 1'b1;
                end
            end
            SRC_DECODE: begin
                // out-of-range pair or idle decoder gives silence, not stale words
                if (decOn && c.pairSel < DECODE_PAIR_LIMIT) begin
                    r.left = dec[{c.pairSel[1:0], 1'b0}];
                    r.right = dec[{c.pairSel[1:0], 1'b1}];
                    r.ok = 1'b1;
                end
            end
            default: r = '0;
        endcase
        return r;
    endfunction

    // -----------------------------------------------------------------
    // register state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        pair_cfg_type [PAIR_COUNT-1:0] cfg;
    } bus_state_type;

    bus_state_type state;
    bus_state_type next_state;
    pick_type [PAIR_COUNT-1:0] pick;
    logic [PAIR_COUNT-1:0] nonAudioFlags;
    logic [PAIR_COUNT-1:0] bypassFlags;
    logic [2:0] regIndex;
    logic isCfg;
    logic isStatus;
    logic [31:0] rdWord;
    logic [31:0] statusWord;

    assign regIndex = avsReq.address[4:2];
    assign isCfg = avsReq.address < STATUS_OFS && avsReq.address[1:0] == 2'h0;
    assign isStatus = avsReq.address == STATUS_OFS;

    always_comb begin
        statusWord = '0;
        statusWord[STAT_DECODE_BIT] = decoderActive;
        statusWord[STAT_NONAUDIO_LSB +: PAIR_COUNT] = nonAudioFlags;
        statusWord[STAT_BYPASS_LSB +: PAIR_COUNT] = bypassFlags;
    end

    always_comb begin
        next_state = state;
        rdWord = '0;
        if (isCfg) begin
            rdWord = cfg_to_word(state.cfg[regIndex]);
        end else if (isStatus) begin
            rdWord = statusWord;
        end
        if (state.waitrequest) begin
            // one wait cycle lets read data settle into a register
            if (avsReq.read || avsReq.write) begin
                next_state.waitrequest = 1'b0;
                next_state.readdata = avsReq.read ? rdWord : '0;
            end
        end else begin
            next_state.waitrequest = 1'b1;
            if (avsReq.write && isCfg) begin
                // each pair keeps its own source, pair and mode
                next_state.cfg[regIndex] = word_to_cfg(merge_bytes(
                    cfg_to_word(state.cfg[regIndex]), avsReq.writedata, avsReq.byteenable));
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state.waitrequest <= 1'b1;
            state.readdata <= '0;
            state.cfg <= {PAIR_COUNT{word_to_cfg(CFG_RESET)}};
        end else begin
            state <= next_state;
        end
    end

    assign avsRsp.readdata = state.readdata;
    assign avsRsp.waitrequest = state.waitrequest;

    // -----------------------------------------------------------------
    // per-pair datapath
    // -----------------------------------------------------------------
    for (genvar p = 0; p < PAIR_COUNT; p++) begin : g_pair
        // pair p drives mixer channels 2p+1 and 2p+2
        assign pick[p] = select_source(state.cfg[p], decoderActive,
                                       sdiWords, aesWords, analogWords, decodeWords);
        pair_mode_unit u_unit (
            .clk_sys(clk_sys),
            .rst(rst),
            .sampleStrobe(sampleStrobe),
            .cfg(state.cfg[p]),
            .pick(pick[p]),
            .outPair(mixPairs[p]),
            .nonAudio(nonAudioFlags[p])
        );
        assign bypassFlags[p] = mixPairs[p].bypass;
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    pair_cfg_type wrImage;
    aes_word_type decodePick;
    aes_word_type sdiPick;
    logic cfgCommit;

    assign wrImage = word_to_cfg(avsReq.writedata);
    assign decodePick = decodeWords[{state.cfg[0].pairSel[1:0], 1'b0}];
    assign sdiPick = sdiWords[{state.cfg[0].pairSel, 1'b1}];
    // a strobe right after a committed write that changes a pair's source or pair select is dropped while the unit relearns its route
    assign cfgCommit = avsReq.write && !state.waitrequest;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_wait_one_cycle: assert property (
        (avsReq.read || avsReq.write) && state.waitrequest |=> !state.waitrequest ##1 state.waitrequest)
        else $error("waitrequest did not drop for exactly one cycle");

    a_cfg_write_lands: assert property (
        avsReq.write && !state.waitrequest && avsReq.address == CFG_BASE && &avsReq.byteenable
        |=> state.cfg[0] == $past(wrImage))
        else $error("config write did not land in pair 0");

    a_decode_idle_mute: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[0].source == SRC_DECODE && !decoderActive
        |=> !mixPairs[0].valid && mixPairs[0].left == '0)
        else $error("idle decoder reached the mixer");

    a_decode_range: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[0].source == SRC_DECODE
        && state.cfg[0].pairSel >= DECODE_PAIR_LIMIT |=> !mixPairs[0].valid)
        else $error("decoder pair beyond four was accepted");

    a_decode_route: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[0].source == SRC_DECODE && decoderActive
        && state.cfg[0].pairSel < DECODE_PAIR_LIMIT
        |=> mixPairs[0].valid && mixPairs[0].left == $past(decodePick))
        else $error("decoder pair not routed");

    a_sdi_route: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[0].source == SRC_SDI
        |=> mixPairs[0].valid && mixPairs[0].right == $past(sdiPick))
        else $error("embedded pair not routed");

    a_data_bypass: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[1].mode == MODE_DATA
        |=> mixPairs[1].bypass)
        else $error("data mode did not bypass");

    a_audio_mixed: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[2].mode == MODE_AUDIO
        |=> !mixPairs[2].bypass)
        else $error("audio mode bypassed the mixer");

    a_auto_follows: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[3].mode == MODE_AUTO
        |=> mixPairs[3].bypass == nonAudioFlags[3])
        else $error("auto mode ignored the non-audio flag");

    a_mode_three_audio: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[3].mode == 2'h3
        |=> !mixPairs[3].bypass)
        else $error("spare mode code bypassed the mixer");

    a_data_words_kept: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[1].mode == MODE_DATA && pick[1].ok
        |=> mixPairs[1].left == $past(pick[1].left) && mixPairs[1].right == $past(pick[1].right))
        else $error("data mode pair was altered");

    a_last_pair_sdi: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[7].source == SRC_SDI
        |=> mixPairs[7].left == $past(sdiWords[{state.cfg[7].pairSel, 1'b0}]))
        else $error("embedded pair for the last mixer pair not routed");

    a_aes_pair_valid: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[5].source == SRC_AES
        |=> mixPairs[5].valid && mixPairs[5].right == $past(aesWords[{state.cfg[5].pairSel, 1'b1}]))
        else $error("external digital pair not routed");

    a_analog_range: assert property (
        sampleStrobe && !$past(cfgCommit) && state.cfg[2].source == SRC_ANALOG
        && state.cfg[2].pairSel >= ANALOG_PAIR_LIMIT |=> !mixPairs[2].valid)
        else $error("analog pair beyond two was accepted");

    a_status_decode: assert property (
        avsReq.read && isStatus && state.waitrequest
        |=> state.readdata[STAT_DECODE_BIT] == $past(decoderActive))
        else $error("status read missed the decoder state");

    a_status_bypass: assert property (
        avsReq.read && isStatus && state.waitrequest
        |=> state.readdata[STAT_BYPASS_LSB +: PAIR_COUNT] == $past(bypassFlags))
        else $error("status read missed the bypass flags");

    a_unmapped_read: assert property (
        avsReq.read && state.waitrequest && !isCfg && !isStatus
        |=> state.readdata == '0)
        else $error("unmapped read returned data");

    a_write_ignored: assert property (
        avsReq.write && !state.waitrequest && !isCfg
        |=> state.cfg == $past(state.cfg))
        else $error("write outside the config words changed a pair");

    a_valid_pulse: assert property (
        mixPairs[4].valid |-> $past(sampleStrobe))
        else $error("output valid without a sample strobe");

    c_decode_used: cover property (sampleStrobe && decoderActive && state.cfg[0].source == SRC_DECODE);
    c_data_mode: cover property (mixPairs[1].valid && mixPairs[1].bypass);
    c_auto_data: cover property (mixPairs[3].valid && nonAudioFlags[3]);
    c_status_read: cover property (avsReq.read && isStatus && !state.waitrequest);
endmodule
`default_nettype wire

// *** testbench/source_feed_model.sv ***
// Purpose: far-side model of the sources: video embedded, external digital, analog and decoder words
// Assumes: one clock; words only move on a taken strobe
// Notes: every word carries its source, channel and frame so a misroute shows at once
`default_nettype none
module source_feed_model
    import mixer_route_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sampleStrobe,
    input wire logic dataFlag,
    output var mixer_route_pkg::aes_word_type [15:0] sdiWords,
    output var mixer_route_pkg::aes_word_type [15:0] aesWords,
    output var mixer_route_pkg::aes_word_type [3:0] analogWords,
    output var mixer_route_pkg::aes_word_type [7:0] decodeWords
);
    logic [7:0] frame;

    // ---------------------------------------------------------------
    // channel status block position
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || (sampleStrobe && frame == CS_FRAME_LAST)) begin
            frame <= 8'h00;
        end else if (sampleStrobe) begin
            frame <= frame + 8'h01;
        end
    end

    // user, validity and status bits vary too, so a bypass that drops any bit is caught
    function automatic aes_word_type mk(input logic [1:0] s, input logic [3:0] ch, input logic [7:0] f,
                                        input logic fl);
        aes_word_type w;
        w.audio = {s, ch, 2'h0, f, 8'h5a ^ {4'h0, ch}};
        w.blockStart = (f == 8'h00);
        w.chanStat = (f == CS_NONAUDIO_FRAME) ? fl : f[2];
        w.user = f[0];
        w.validity = ch[0];
        w.parity = ^w.audio;
        return w;
    endfunction

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            sdiWords[i] = mk(SRC_SDI, 4'(i), frame, dataFlag);
            aesWords[i] = mk(SRC_AES, 4'(i), frame, dataFlag);
        end
        for (int i = 0; i < 4; i++) begin
            analogWords[i] = mk(SRC_ANALOG, 4'(i), frame, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            decodeWords[i] = mk(SRC_DECODE, 4'(i), frame, 1'b0);
        end
    end
endmodule
`default_nettype wire

// *** testbench/mixer_input_source_router_test.sv ***
// Purpose: self-checking bench for the mixer input source router
// Assumes: one wait cycle per register access is not relied on; bus waits are bounded
// Notes: refused routes are only driven in audio mode, so their bypass is expected low
`default_nettype none
module mixer_input_source_router_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mixer_route_pkg::*;

    logic clk_sys, rst, decoderActive, sampleStrobe, dataFlag, autoData;
    avs_req_type avsReq;
    avs_rsp_type avsRsp;
    aes_word_type [15:0] sdiWords, aesWords;
    aes_word_type [3:0] analogWords;
    aes_word_type [7:0] decodeWords;
    mix_pair_type [7:0] mixPairs;
    logic [1:0] pSrc [8];
    logic [2:0] pSel [8];
    logic [1:0] pMode [8];
    logic [7:0] bypassMask;
    logic [31:0] scratch;
    int failures, checked;

    mixer_input_source_router uut (.clk_sys(clk_sys), .rst(rst), .avsReq(avsReq), .avsRsp(avsRsp),
        .decoderActive(decoderActive), .sampleStrobe(sampleStrobe), .sdiWords(sdiWords),
        .aesWords(aesWords), .analogWords(analogWords), .decodeWords(decodeWords), .mixPairs(mixPairs));
    source_feed_model feed (.clk_sys(clk_sys), .rst(rst), .sampleStrobe(sampleStrobe), .dataFlag(dataFlag),
        .sdiWords(sdiWords), .aesWords(aesWords), .analogWords(analogWords), .decodeWords(decodeWords));

    // ---------------------------------------------------------------
    // reporting
    // ---------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t register got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chkPair(input int p, input mix_pair_type g, input mix_pair_type e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t pair %0d got %h expected %h", $time, p, g, e);
        end
    endtask

    // ---------------------------------------------------------------
    // register access
    // ---------------------------------------------------------------
    // a leading edge keeps two requests from being driven in one time step
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        avsReq.read <= !wr;
        avsReq.write <= wr;
        avsReq.address <= a;
        avsReq.writedata <= d;
        // look between edges so the registered waitrequest is never read mid-update; the watchdog ends a hang
        @(negedge clk_sys);
        while (avsRsp.waitrequest !== 1'b0) begin
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        q = avsRsp.readdata;
        avsReq.read <= 1'b0;
        avsReq.write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk32(q, e);
    endtask

    task automatic set_pair(input int p, input logic [1:0] s, input logic [2:0] k, input logic [1:0] m);
        logic [31:0] q;
        pSrc[p] = s;
        pSel[p] = k;
        pMode[p] = m;
        bus(1'b1, CFG_BASE + 6'(4 * p), {22'h0, m, 1'b0, k, 2'h0, s}, q);
    endtask

    // ---------------------------------------------------------------
    // sample path
    // ---------------------------------------------------------------
    function automatic mix_pair_type want(input int p);
        mix_pair_type m;
        logic ok;
        int i;
        m = '0;
        i = 2 * int'(pSel[p]);
        ok = pSrc[p] == SRC_SDI || pSrc[p] == SRC_AES || (pSrc[p] == SRC_ANALOG && pSel[p] < ANALOG_PAIR_LIMIT)
            || (pSrc[p] == SRC_DECODE && decoderActive === 1'b1 && pSel[p] < DECODE_PAIR_LIMIT);
        if (ok) begin
            case (pSrc[p])
                SRC_SDI: {m.left, m.right} = {sdiWords[i], sdiWords[i + 1]};
                SRC_AES: {m.left, m.right} = {aesWords[i], aesWords[i + 1]};
                SRC_ANALOG: {m.left, m.right} = {analogWords[i], analogWords[i + 1]};
                default: {m.left, m.right} = {decodeWords[i], decodeWords[i + 1]};
            endcase
            m.valid = 1'b1;
            m.bypass = pMode[p] == MODE_DATA || (pMode[p] == MODE_AUTO && autoData);
        end
        return m;
    endfunction

    task automatic check_sample();
        mix_pair_type e [8];
        @(posedge clk_sys);
        sampleStrobe <= 1'b1;
        @(negedge clk_sys);
        for (int p = 0; p < 8; p++) begin
            e[p] = want(p);
            bypassMask[p] = e[p].bypass;
        end
        @(posedge clk_sys);
        sampleStrobe <= 1'b0;
        @(negedge clk_sys);
        for (int p = 0; p < 8; p++) begin
            chkPair(p, mixPairs[p], e[p]);
        end
    endtask

    // back-to-back strobes walk the channel status block
    task automatic run_strobes(input int n);
        @(posedge clk_sys);
        sampleStrobe <= 1'b1;
        repeat (n) @(posedge clk_sys);
        sampleStrobe <= 1'b0;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        #200_000;
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        avsReq = '0;
        avsReq.byteenable = 4'hf;
        decoderActive = 1'b0;
        sampleStrobe = 1'b0;
        dataFlag = 1'b0;
        autoData = 1'b0;
        failures = 0;
        checked = 0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (int p = 0; p < 8; p++) begin
            rd_chk(CFG_BASE + 6'(4 * p), CFG_RESET);
        end
        rd_chk(STATUS_OFS, 32'h0);
        bus(1'b1, 6'h24, 32'hffff_ffff, scratch);
        bus(1'b1, STATUS_OFS, 32'hffff_ffff, scratch);
        rd_chk(STATUS_OFS, 32'h0);
        rd_chk(6'h24, 32'h0);
        rd_chk(6'h02, 32'h0);
        @(posedge clk_sys);
        decoderActive <= 1'b1;
        // every source, every pair select across the eight pairs
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 8; p++) begin
                set_pair(p, 2'(s), 3'(p), MODE_AUDIO);
            end
            check_sample();
        end
        @(posedge clk_sys);
        decoderActive <= 1'b0;
        check_sample();
        rd_chk(STATUS_OFS, 32'h0);
        @(posedge clk_sys);
        decoderActive <= 1'b1;
        // modes per pair, with the mode code three read as audio
        for (int p = 0; p < 8; p++) begin
            set_pair(p, p[0] ? SRC_SDI : SRC_AES, 3'(7 - p), 2'(p));
        end
        check_sample();
        check_sample();
        rd_chk(STATUS_OFS, {8'h0, bypassMask, 8'h00, 8'h01});
        // auto mode follows the data flag both ways
        dataFlag <= 1'b1;
        for (int p = 0; p < 8; p++) begin
            set_pair(p, SRC_SDI, 3'(p), MODE_AUTO);
        end
        run_strobes(200);
        autoData = 1'b1;
        check_sample();
        rd_chk(STATUS_OFS, 32'h00ff_ff01);
        @(posedge clk_sys);
        dataFlag <= 1'b0;
        run_strobes(200);
        autoData = 1'b0;
        check_sample();
        rd_chk(STATUS_OFS, 32'h0000_0001);
        tally_and_finish();
    end
endmodule
`default_nettype wire
